// *** core/sdecc_pkg.sv ***
// Package: register map, field positions, codes and beat type of the SDRAM ECC datapath
// ============================================================
package sdecc_pkg;
  // ============================================================
  // Register map
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] ADDR_ERR_ONE = 8'hc0;
  localparam logic [7:0] ADDR_ERR_TWO = 8'hc4;
  localparam logic [7:0] ADDR_STATUS  = 8'hd0;
  localparam logic [7:0] ADDR_CLEAR   = 8'hd4;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'hd8;
  localparam logic [7:0] ADDR_MC_ONE  = 8'hf0;
  localparam logic [7:0] ADDR_MC_TWO  = 8'hf4;
  localparam logic [7:0] ADDR_MC_FOUR = 8'hfc;
  // ============================================================
  // Field positions
  localparam int BIT_RAM_TYPE    = 17;
  localparam int BIT_REG_PAR     = 16;
  localparam int BIT_EXT_OUT     = 16;
  localparam int BIT_INL_WR      = 19;
  localparam int BIT_INL_RD      = 18;
  localparam int BIT_INL_METHOD  = 20;
  localparam int BIT_RMW         = 0;
  localparam int BIT_BUF_HI      = 22;
  localparam int BIT_BUF_LO      = 20;
  localparam int BIT_MEMPAR_EN   = 2;
  localparam int BIT_MULTIBIT_EN = 3;
  // ============================================================
  // Buffer codes and reset values
  localparam logic [1:0]  BUF_REGISTERED = 2'b01;
  localparam logic [1:0]  BUF_INLINE     = 2'b10;
  localparam logic [31:0] MC_FOUR_RESET  = 32'h0010_0000;
  localparam logic [31:0] MC_RESET       = 32'h0000_0000;
  localparam logic [7:0]  ERR_RESET      = 8'h00;
  // ============================================================
  // Interrupt status bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_READ_ERR  = 0;
  localparam int IRQ_MULTI     = 1;
  localparam int IRQ_WRITE_PAR = 2;
  // ============================================================
  // Address mux, physical bits numbered 0 = msb
  localparam int PA_ROW12   = 6;
  localparam int PA_ROW11   = 7;
  localparam int PA_BA1     = 8;
  localparam int PA_BA0     = 9;
  localparam int PA_ROW_LO  = 10;
  localparam int PA_COL_LO  = 21;
  localparam int PA_COL11   = 3;
  localparam int PA_COL9    = 4;
  localparam int PA_COL8    = 5;
  localparam int ROW_LO_W   = 11;
  localparam int COL_LO_W   = 8;
  // ============================================================
  // Data beat toward memory
  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  chk;
    logic [7:0]  be;
  } sdecc_beat_s;

  // Even parity per byte: check bit j covers data byte j
  function automatic logic [7:0] byte_parity(input logic [63:0] d);
    logic [7:0] p;
    for (int j = 0; j < 8; j++) begin
      p[j] = ^d[8*j +: 8];
    end
    return p;
  endfunction
endpackage

// *** core/sdecc_codec.sv ***
// Check-bit generator, checker and single-bit corrector for one 64-bit word
`timescale 1ns/100ps
module sdecc_codec (
  // Word under test
  input  wire logic [63:0] data,
  input  wire logic [7:0]  chk_in,
  input  wire logic        par_mode,
  // Results
  output logic      [63:0] data_fix,
  output logic      [7:0]  chk_gen,
  output logic             err_single,
  output logic             err_multi,
  output logic             err_par
);
  logic [7:0] ecc;
  logic [7:0] par;
  logic [7:0] syn;
  logic       hit;

  // Odd-weight columns: any double error gives an even syndrome, never a column
  function automatic logic [7:0] col_code(input int idx);
    int         n;
    logic [7:0] code;
    n = 0;
    code = 8'h00;
    for (int w = 3; w <= 5; w += 2) begin
      for (int v = 0; v < 256; v++) begin
        if ($countones(v[7:0]) == w) begin
          if (n == idx) code = v[7:0];
          n++;
        end
      end
    end
    return code;
  endfunction

  // ============================================================
  // Generate, check, correct
  always_comb begin
    ecc = 8'h00;
    for (int i = 0; i < 64; i++) begin
      ecc = ecc ^ (col_code(i) & {8{data[i]}});
    end
    par = sdecc_pkg::byte_parity(data);
    chk_gen = par_mode ? par : ecc;
    syn = ecc ^ chk_in;
    data_fix = data;
    hit = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (!par_mode && syn != 8'h00 && col_code(i) == syn) begin
        data_fix[i] = ~data[i];
        hit = 1'b1;
      end
    end
    err_single = !par_mode && syn != 8'h00 && (hit || $countones(syn) == 1);
    err_multi = !par_mode && syn != 8'h00 && !(hit || $countones(syn) == 1);
    err_par = par_mode && (par != chk_in);
  end
endmodule

// *** core/sdecc_datapath.sv ***
// SDRAM memory data path: buffering, check bits, address mux and configuration registers
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module sdecc_datapath #(
  parameter int COL11 = 0
) (
  // Clock, reset, enable
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       clk_en,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sdecc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  // Processor side write
  input  wire logic                       cpu_wr_valid,
  input  wire logic [63:0]                cpu_wdata,
  input  wire logic [7:0]                 cpu_wbe,
  input  wire logic [7:0]                 cpu_wpar,
  // Processor side read
  output logic                            cpu_rd_valid,
  output logic      [63:0]                cpu_rdata,
  output logic      [7:0]                 cpu_rpar,
  // Memory data and check lines
  input  wire logic                       mem_rd_valid,
  input  wire logic [31:0]                mem_data_upper_i,
  output logic      [31:0]                mem_data_upper_o,
  output logic                            mem_data_upper_oe,
  input  wire logic [31:0]                mem_data_lower_i,
  output logic      [31:0]                mem_data_lower_o,
  output logic                            mem_data_lower_oe,
  input  wire logic [7:0]                 check_bit_lines_i,
  output logic      [7:0]                 check_bit_lines_o,
  output logic                            check_bit_lines_oe,
  output logic      [7:0]                 byte_lane_mask,
  // Address multiplexing
  input  wire logic [0:31]                phys_addr,
  input  wire logic                       row_phase,
  input  wire logic                       column_phase,
  output logic      [12:0]                muxed_row_col_lines,
  output logic      [1:0]                 bank_select_lines,
  // Memory type outputs
  output logic                            sdram_init_enable,
  output logic                            extended_out_select
);
  if (COL11 != 0 && COL11 != 1) begin : g_bad_col11
    $error("COL11 must be 0 or 1");
  end

  // ============================================================
  // Registers
  logic [7:0]                  err_one_r;
  logic [7:0]                  err_two_r;
  logic [31:0]                 mc_one_r;
  logic [31:0]                 mc_two_r;
  logic [31:0]                 mc_four_r;
  logic [sdecc_pkg::IRQ_W-1:0] irq_en_r;
  logic [sdecc_pkg::IRQ_W-1:0] status_r;
  logic [sdecc_pkg::IRQ_W-1:0] event_nxt;
  logic [sdecc_pkg::IRQ_W-1:0] clear_nxt;
  logic [31:0]                 rd_nxt;
  logic                        hit_nxt;
  logic                        wr_go;

  assign pready = clk_en;
  assign wr_go = psel && penable && pwrite && clk_en;
  assign pslverr = psel && penable && !hit_nxt;

  always_comb begin
    hit_nxt = 1'b1;
    rd_nxt = 32'h0000_0000;
    if (paddr == sdecc_pkg::ADDR_ERR_ONE) begin
      rd_nxt = {24'h000000, err_one_r};
    end else if (paddr == sdecc_pkg::ADDR_ERR_TWO) begin
      rd_nxt = {24'h000000, err_two_r};
    end else if (paddr == sdecc_pkg::ADDR_STATUS) begin
      rd_nxt = {{(32-sdecc_pkg::IRQ_W){1'b0}}, status_r};
    end else if (paddr == sdecc_pkg::ADDR_CLEAR) begin
      rd_nxt = 32'h0000_0000;
    end else if (paddr == sdecc_pkg::ADDR_IRQ_EN) begin
      rd_nxt = {{(32-sdecc_pkg::IRQ_W){1'b0}}, irq_en_r};
    end else if (paddr == sdecc_pkg::ADDR_MC_ONE) begin
      rd_nxt = mc_one_r;
    end else if (paddr == sdecc_pkg::ADDR_MC_TWO) begin
      rd_nxt = mc_two_r;
    end else if (paddr == sdecc_pkg::ADDR_MC_FOUR) begin
      rd_nxt = mc_four_r;
    end else begin
      hit_nxt = 1'b0;
    end
  end

  // Read data captured in setup so it leaves a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= rd_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_one_r <= sdecc_pkg::ERR_RESET;
      err_two_r <= sdecc_pkg::ERR_RESET;
      mc_one_r <= sdecc_pkg::MC_RESET;
      mc_two_r <= sdecc_pkg::MC_RESET;
      mc_four_r <= sdecc_pkg::MC_FOUR_RESET;
      irq_en_r <= '0;
    end else if (wr_go) begin
      if (paddr == sdecc_pkg::ADDR_ERR_ONE) begin
        err_one_r <= pwdata[7:0];
      end else if (paddr == sdecc_pkg::ADDR_ERR_TWO) begin
        err_two_r <= pwdata[7:0];
      end else if (paddr == sdecc_pkg::ADDR_IRQ_EN) begin
        irq_en_r <= pwdata[sdecc_pkg::IRQ_W-1:0];
      end else if (paddr == sdecc_pkg::ADDR_MC_ONE) begin
        mc_one_r <= pwdata;
      end else if (paddr == sdecc_pkg::ADDR_MC_TWO) begin
        mc_two_r <= pwdata;
      end else if (paddr == sdecc_pkg::ADDR_MC_FOUR) begin
        mc_four_r <= pwdata;
      end
    end
  end

  // ============================================================
  // Mode decode
  logic [1:0] buf_mode;
  logic       sdram;
  logic       inline_on;
  logic       reg_par_on;
  logic       inl_wr_chk;
  logic       inl_rd_chk;
  logic       inl_par;

  assign sdram = !mc_one_r[sdecc_pkg::BIT_RAM_TYPE];
  assign sdram_init_enable = sdram;
  assign extended_out_select = !sdram && mc_two_r[sdecc_pkg::BIT_EXT_OUT];
  assign buf_mode = {mc_four_r[sdecc_pkg::BIT_BUF_HI], mc_four_r[sdecc_pkg::BIT_BUF_LO]};
  // Reserved buffer codes fall back to the registered path with all checking off
  assign inline_on = sdram && buf_mode == sdecc_pkg::BUF_INLINE;
  assign reg_par_on = mc_one_r[sdecc_pkg::BIT_REG_PAR]
                      && buf_mode == sdecc_pkg::BUF_REGISTERED;
  assign inl_wr_chk = inline_on && mc_two_r[sdecc_pkg::BIT_INL_WR];
  assign inl_rd_chk = inline_on && mc_two_r[sdecc_pkg::BIT_INL_RD];
  assign inl_par = mc_two_r[sdecc_pkg::BIT_INL_METHOD];

  // ============================================================
  // Write path
  sdecc_pkg::sdecc_beat_s w1_r;
  sdecc_pkg::sdecc_beat_s w2_r;
  sdecc_pkg::sdecc_beat_s out_beat;
  logic                   w1_v_r;
  logic                   w2_v_r;
  logic                   out_v;
  logic [7:0]             w1_par_r;
  logic [7:0]             gen_chk;
  logic                   wpar_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1_r <= '0;
      w1_v_r <= 1'b0;
      w1_par_r <= 8'h00;
    end else if (clk_en) begin
      w1_v_r <= cpu_wr_valid;
      if (cpu_wr_valid) begin
        w1_r.data <= cpu_wdata;
        w1_r.be <= cpu_wbe;
        w1_r.chk <= reg_par_on ? sdecc_pkg::byte_parity(cpu_wdata) : 8'h00;
        w1_par_r <= cpu_wpar;
      end
    end
  end

  sdecc_codec u_gen (
    .data       (w1_r.data),
    .chk_in     (8'h00),
    .par_mode   (inl_par),
    .data_fix   (),
    .chk_gen    (gen_chk),
    .err_single (),
    .err_multi  (),
    .err_par    ()
  );

  // Second stage takes the beat with the check bits formed from the first stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w2_r <= '0;
      w2_v_r <= 1'b0;
    end else if (clk_en) begin
      w2_v_r <= w1_v_r;
      if (w1_v_r) begin
        w2_r.data <= w1_r.data;
        w2_r.be <= w1_r.be;
        w2_r.chk <= gen_chk;
      end
    end
  end

  assign wpar_err = w1_v_r && inl_wr_chk
                    && sdecc_pkg::byte_parity(w1_r.data) != w1_par_r;
  assign out_beat = inline_on ? w2_r : w1_r;
  assign out_v = inline_on ? w2_v_r : w1_v_r;
  assign mem_data_upper_o = out_beat.data[63:32];
  assign mem_data_lower_o = out_beat.data[31:0];
  assign check_bit_lines_o = out_beat.chk;
  assign mem_data_upper_oe = out_v;
  assign mem_data_lower_oe = out_v;
  assign check_bit_lines_oe = out_v;
  assign byte_lane_mask = out_v ? ~out_beat.be : 8'h00;

  // ============================================================
  // Read path
  logic [63:0] r1_data_r;
  logic [7:0]  r1_chk_r;
  logic        r1_v_r;
  logic [63:0] r2_data_r;
  logic [7:0]  r2_par_r;
  logic        r2_v_r;
  logic [63:0] fix_data;
  logic        rd_single;
  logic        rd_multi;
  logic        rd_par;
  logic        rpar_err;
  logic        inl_rd_err;
  logic        inl_multi;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r1_data_r <= 64'h0;
      r1_chk_r <= 8'h00;
      r1_v_r <= 1'b0;
    end else if (clk_en) begin
      r1_v_r <= mem_rd_valid;
      if (mem_rd_valid) begin
        r1_data_r <= {mem_data_upper_i, mem_data_lower_i};
        r1_chk_r <= check_bit_lines_i;
      end
    end
  end

  sdecc_codec u_chk (
    .data       (r1_data_r),
    .chk_in     (r1_chk_r),
    .par_mode   (inl_par),
    .data_fix   (fix_data),
    .chk_gen    (),
    .err_single (rd_single),
    .err_multi  (rd_multi),
    .err_par    (rd_par)
  );

  // Correction sits inside the in-line stage, so it costs no extra cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r2_data_r <= 64'h0;
      r2_par_r <= 8'h00;
      r2_v_r <= 1'b0;
    end else if (clk_en) begin
      r2_v_r <= r1_v_r;
      if (r1_v_r) begin
        r2_data_r <= (inl_rd_chk && !inl_par) ? fix_data : r1_data_r;
        r2_par_r <= sdecc_pkg::byte_parity((inl_rd_chk && !inl_par) ? fix_data : r1_data_r);
      end
    end
  end

  assign rpar_err = r1_v_r && reg_par_on
                    && sdecc_pkg::byte_parity(r1_data_r) != r1_chk_r;
  assign inl_rd_err = r1_v_r && inl_rd_chk && (inl_par ? rd_par : rd_single);
  assign inl_multi = r1_v_r && inl_rd_chk && !inl_par && rd_multi;
  assign cpu_rd_valid = inline_on ? r2_v_r : r1_v_r;
  assign cpu_rdata = inline_on ? r2_data_r : r1_data_r;
  assign cpu_rpar = inline_on ? r2_par_r : r1_chk_r;

  // ============================================================
  // Interrupt status
  always_comb begin
    event_nxt = '0;
    event_nxt[sdecc_pkg::IRQ_READ_ERR] = (rpar_err || inl_rd_err)
                                         && err_one_r[sdecc_pkg::BIT_MEMPAR_EN];
    event_nxt[sdecc_pkg::IRQ_MULTI] = inl_multi && err_two_r[sdecc_pkg::BIT_MULTIBIT_EN];
    event_nxt[sdecc_pkg::IRQ_WRITE_PAR] = wpar_err;
    clear_nxt = '0;
    if (wr_go && paddr == sdecc_pkg::ADDR_CLEAR) begin
      clear_nxt = pwdata[sdecc_pkg::IRQ_W-1:0];
    end
  end

  // A fresh event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else if (clk_en) begin
      status_r <= (status_r & ~clear_nxt) | event_nxt;
    end
  end

  assign irq = |(status_r & irq_en_r);

  // ============================================================
  // Address multiplexing, 13 row x 8 column (11 with COL11 = 1) x 4 bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      muxed_row_col_lines <= 13'h0000;
      bank_select_lines <= 2'b00;
    end else if (clk_en) begin
      if (row_phase) begin
        muxed_row_col_lines[12] <= phys_addr[sdecc_pkg::PA_ROW12];
        muxed_row_col_lines[11] <= phys_addr[sdecc_pkg::PA_ROW11];
        muxed_row_col_lines[10:0] <= phys_addr[sdecc_pkg::PA_ROW_LO +: sdecc_pkg::ROW_LO_W];
        bank_select_lines <= {phys_addr[sdecc_pkg::PA_BA1], phys_addr[sdecc_pkg::PA_BA0]};
      end else if (column_phase) begin
        muxed_row_col_lines[7:0] <= phys_addr[sdecc_pkg::PA_COL_LO +: sdecc_pkg::COL_LO_W];
        // Line 10 low means no autoprecharge
        muxed_row_col_lines[12:8] <= (COL11 == 1)
          ? {1'b0, phys_addr[sdecc_pkg::PA_COL11], 1'b0,
             phys_addr[sdecc_pkg::PA_COL9], phys_addr[sdecc_pkg::PA_COL8]}
          : 5'h00;
        bank_select_lines <= {phys_addr[sdecc_pkg::PA_BA1], phys_addr[sdecc_pkg::PA_BA0]};
      end
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_row_map;
    clk_en && row_phase |=> muxed_row_col_lines[12] == $past(phys_addr[6])
      && muxed_row_col_lines[0] == $past(phys_addr[20]) && bank_select_lines[1] == $past(phys_addr[8]);
  endproperty
  a_row_map: assert property (p_row_map) else $error("row map wrong");

  property p_col_map;
    clk_en && column_phase && !row_phase |=> !muxed_row_col_lines[10]
      && muxed_row_col_lines[7] == $past(phys_addr[21]);
  endproperty
  a_col_map: assert property (p_col_map) else $error("column map wrong");

  property p_reg_latency;
    clk_en && cpu_wr_valid && !inline_on |=> mem_data_lower_oe
      && mem_data_lower_o == $past(cpu_wdata[31:0]);
  endproperty
  a_reg_latency: assert property (p_reg_latency) else $error("registered latency wrong");

  property p_inl_latency;
    clk_en && cpu_wr_valid && inline_on ##1 clk_en && inline_on |=> check_bit_lines_oe;
  endproperty
  a_inl_latency: assert property (p_inl_latency) else $error("inline latency wrong");

  property p_mask;
    clk_en && cpu_wr_valid && !inline_on |=> byte_lane_mask == ~$past(cpu_wbe);
  endproperty
  a_mask: assert property (p_mask) else $error("byte mask wrong");

  property p_init;
    wr_go && paddr == sdecc_pkg::ADDR_MC_ONE && pwdata[sdecc_pkg::BIT_RAM_TYPE]
      |=> !sdram_init_enable;
  endproperty
  a_init: assert property (p_init) else $error("init enable wrong");

  property p_wpar_gate;
    !inl_wr_chk |=> !$rose(status_r[sdecc_pkg::IRQ_WRITE_PAR]);
  endproperty
  a_wpar_gate: assert property (p_wpar_gate) else $error("write parity outside inline");

  property p_regpar_gate;
    !reg_par_on && !inline_on |=> !$rose(status_r[sdecc_pkg::IRQ_READ_ERR]);
  endproperty
  a_regpar_gate: assert property (p_regpar_gate) else $error("read parity without enable");

  property p_fix;
    // A single data or check-bit error comes out corrected on the next cycle
    clk_en && inl_rd_chk && !inl_par && r1_v_r && rd_single |=> cpu_rd_valid
      && cpu_rdata == $past(fix_data);
  endproperty
  a_fix: assert property (p_fix) else $error("single error not corrected");

  property p_multi;
    clk_en && inl_multi && err_two_r[sdecc_pkg::BIT_MULTIBIT_EN]
      |=> status_r[sdecc_pkg::IRQ_MULTI];
  endproperty
  a_multi: assert property (p_multi) else $error("multibit not flagged");

  property p_method;
    inl_par |-> !rd_multi && !rd_single;
  endproperty
  a_method: assert property (p_method) else $error("ecc result in parity mode");

  c_reg_write: cover property (clk_en && cpu_wr_valid && !inline_on ##1 mem_data_lower_oe);
  c_inl_write: cover property (clk_en && cpu_wr_valid && inline_on ##2 mem_data_lower_oe);
  c_fix: cover property (inl_rd_chk && r1_v_r && rd_single);
  c_multi: cover property (status_r[sdecc_pkg::IRQ_MULTI] && irq);
endmodule

// *** test/sdecc_mem_model.sv ***
// Memory-side model: keeps the last written beat and returns it on reads
`timescale 1ns/100ps
module sdecc_mem_model (
  // Clock and write side from the datapath
  input  wire logic        pclk,
  input  wire logic [71:0] wr_word,
  input  wire logic        wr_oe,
  // Read request and fault pattern from the bench
  input  wire logic        rd,
  input  wire logic [71:0] flip,
  output logic      [71:0] rd_word
);
  logic [71:0] mem_r;
  always_ff @(posedge pclk) if (wr_oe) mem_r <= wr_word;
  // Released bus shows the inverse, so a stale copy never passes
  assign rd_word = rd ? mem_r ^ flip : ~mem_r;
endmodule

// *** test/tb_sdecc_datapath.sv ***
// Bench: registers, buffering, check bits, interrupt and address mux of the datapath
`timescale 1ns/100ps
module tb_sdecc_datapath;
  // ============================================================
  // Signals
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, cpu_wbe = 0, cpu_wpar = 0, check_bit_lines_o, byte_lane_mask, cpu_rpar;
  logic [31:0] pwdata = 0, prdata, mem_data_upper_o, mem_data_lower_o, v;
  logic        pready, pslverr, irq, cpu_wr_valid = 0, cpu_rd_valid, mem_rd_valid = 0, mrd = 0;
  logic        mem_data_upper_oe, mem_data_lower_oe, check_bit_lines_oe, row_phase = 0, se;
  logic        column_phase = 0, sdram_init_enable, extended_out_select;
  logic [63:0] cpu_wdata = 0, cpu_rdata;
  logic [0:31] phys_addr = 0;
  logic [12:0] muxed_row_col_lines;
  logic [1:0]  bank_select_lines;
  logic [71:0] flip = 0;
  wire  [31:0] mem_data_upper_i, mem_data_lower_i;
  wire  [7:0]  check_bit_lines_i;
  int          n_fail = 0, check_count = 0;
  localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;

  sdecc_datapath uut (.*);
  sdecc_mem_model mem (.pclk(pclk), .wr_oe(mem_data_upper_oe), .rd(mrd), .flip(flip),
    .wr_word({mem_data_upper_o, mem_data_lower_o, check_bit_lines_o}),
    .rd_word({mem_data_upper_i, mem_data_lower_i, check_bit_lines_i}));

  always #50 pclk = ~pclk;
  // ============================================================
  // Shared tasks
  function automatic logic [7:0] par(input logic [63:0] d);
    for (int j = 0; j < 8; j++) par[j] = ^d[8*j +: 8];
  endfunction
  task automatic chk(input logic [71:0] s, input logic [71:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Write beat; pm compares check bits to byte parity, pe corrupts bus parity
  task automatic wr(input int lat, input logic [63:0] d, input logic [7:0] be, input logic pm,
                    input logic [7:0] pe);
    cpu_wr_valid <= 1;
    cpu_wdata <= d;
    cpu_wbe <= be;
    cpu_wpar <= par(d) ^ pe;
    @(posedge pclk);
    cpu_wr_valid <= 0;
    for (int i = 1; i <= lat; i++) begin
      @(negedge pclk);
      chk(72'(mem_data_upper_oe), 72'(i == lat));
      if (i < lat) @(posedge pclk);
    end
    chk(72'({mem_data_upper_o, mem_data_lower_o}), 72'(d));
    chk(72'(byte_lane_mask), 72'(be ^ 8'hff));
    if (pm) chk(72'(check_bit_lines_o), 72'(par(d)));
    @(posedge pclk);
  endtask
  task automatic rdb(input int lat, input logic [71:0] f, input logic [63:0] e);
    flip <= f;
    mrd <= 1;
    mem_rd_valid <= 1;
    @(posedge pclk);
    mem_rd_valid <= 0;
    mrd <= 0;
    repeat (lat - 1) @(posedge pclk);
    @(negedge pclk);
    chk(72'(cpu_rd_valid), 72'h1);
    chk(72'(cpu_rdata), 72'(e));
    chk(72'(cpu_rpar), 72'(par(e) ^ (lat == 1 ? f[7:0] : 8'h00)));
    @(posedge pclk);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    chk(72'(sdram_init_enable), 72'h1);
    apb(0, 8'hfc, 0);
    chk(72'(v), 72'h0010_0000);
    apb(0, 8'he0, 0);
    chk(72'({se, v}), 72'h1_0000_0000);
  endtask
  task automatic t_memtype;
    apb(1, 8'hf0, 32'h0002_0000);
    apb(1, 8'hf4, 32'h0001_0000);
    chk(72'({sdram_init_enable, extended_out_select}), 72'h1);
    apb(1, 8'hf0, 0);
    chk(72'({sdram_init_enable, extended_out_select}), 72'h2);
  endtask
  task automatic t_regpath;
    apb(1, 8'hc0, 32'h4);
    apb(1, 8'hf0, 32'h0001_0000);
    wr(1, D, 8'h0f, 1, 0);
    rdb(1, 72'h1, D);
    apb(0, 8'hd0, 0);
    chk(72'(v), 72'h1);
    apb(1, 8'hd4, 32'h7);
    apb(1, 8'hf0, 0);
  endtask
  task automatic t_inline_ecc;
    apb(1, 8'hfc, 32'h0040_0000);
    apb(1, 8'hf4, 32'h0004_0001);
    apb(1, 8'hc0, 32'h4);
    apb(1, 8'hc4, 32'h8);
    wr(2, D, 8'hff, 0, 0);
    rdb(2, 72'h1 << 20, D);
    apb(0, 8'hd0, 0);
    chk(72'({irq, v}), 72'h1);
    apb(1, 8'hd8, 32'h7);
    chk(72'(irq), 72'h1);
    apb(1, 8'hd4, 32'h7);
    chk(72'(irq), 72'h0);
    rdb(2, 72'h3 << 8, D ^ 64'h3);
    apb(0, 8'hd0, 0);
    chk(72'(v), 72'h2);
    apb(1, 8'hd4, 32'h7);
  endtask
  task automatic t_inline_par;
    apb(1, 8'hc4, 0);
    apb(1, 8'hf4, 32'h001c_0000);
    wr(2, ~D, 8'h3c, 1, 8'h01);
    rdb(2, 72'h1, ~D);
    apb(0, 8'hd0, 0);
    chk(72'(v), 72'h5);
  endtask
  task automatic t_addr;
    phys_addr <= 32'h5a5a_c3c3;
    row_phase <= 1;
    @(posedge pclk);
    row_phase <= 0;
    column_phase <= 1;
    @(negedge pclk);
    chk(72'({bank_select_lines, muxed_row_col_lines}),
        72'({phys_addr[8:9], phys_addr[6:7], phys_addr[10:20]}));
    @(posedge pclk);
    column_phase <= 0;
    @(negedge pclk);
    chk(72'({bank_select_lines, muxed_row_col_lines}),
        72'({phys_addr[8:9], 5'h0, phys_addr[21:28]}));
    @(posedge pclk);
    // Enable low: lines hold and the bus answers not ready
    clk_en <= 0;
    row_phase <= 1;
    @(posedge pclk);
    @(negedge pclk);
    chk(72'({pready, muxed_row_col_lines}), 72'({6'h00, phys_addr[21:28]}));
    @(posedge pclk);
    clk_en <= 1;
    row_phase <= 0;
    @(posedge pclk);
  endtask
  // ============================================================
  // Verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_memtype;
    t_regpath;
    t_inline_ecc;
    t_inline_par;
    t_addr;
    print_verdict;
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule
